// ===== logic/lpm_defs.vh
// constants for the low power mode controller
`ifndef LPM_DEFS_VH
`define LPM_DEFS_VH
// ==========================================
// register byte addresses
`define LPM_ADDR_STOP_CTRL   8'h38
`define LPM_ADDR_CLK_CTRL    8'h3C
`define LPM_ADDR_STATUS      8'h40
`define LPM_ADDR_TB_CTRL     8'h44
// ==========================================
// stop_mode_control fields
`define LPM_STOP_BIT         7
`define LPM_RELEASE_METHOD_BIT         6
`define LPM_POST_STOP_RETURN_MODE_BIT         5
`define LPM_HOLD_BIT         4
`define LPM_WUT_HI           3
`define LPM_WUT_LO           2
`define LPM_STOP_CTRL_RST    8'h00
// clock_source_control fields
`define LPM_XEN_BIT          7
`define LPM_XTEN_BIT         6
`define LPM_SYSCK_BIT        5
`define LPM_HALT_BIT         2
`define LPM_CLK_CTRL_RST     8'h80
// timebase control fields
`define LPM_TBEN_BIT         0
`define LPM_TBIE_BIT         1
`define LPM_IME_BIT          2
// ==========================================
// warm-up counts, normal return (fc cycles)
`define LPM_WU_N0            32'd196608
`define LPM_WU_N1            32'd65536
`define LPM_WU_N2            32'd49152
`define LPM_WU_N3            32'd16384
// warm-up counts, slow return (fs cycles)
`define LPM_WU_S0            32'd24576
`define LPM_WU_S1            32'd8192
`define LPM_WU_S2            32'd192
`define LPM_WU_S3            32'd64
// machine cycle length in source clock periods
`define LPM_MCYC_PERIODS     3'd4
`endif

// ===== logic/lpm_mode_ctrl.v
// low power mode controller with ahb-lite register slave
// Notes on behaviour
// - halt bit in slow1 enters sleep0
// - sleep0 gates peripherals, resumes on tick fall
// - sleep0 exit restarts cpu in slow1
// - sleep0 independent of timebase enable
// - timebase irq needs all three enables
// - timebase enabled sleep0 sets irq latch
// - stop halts oscillators, holds state
// - stop bit one enters stop mode
// - release method: 0 edge, 1 level
// - resume after warm-up at next instruction
// - return mode: 0 normal, 1 slow1
// - reset pin release returns normal1
// - hold bit 0 floats ports in stop
// - hold bit 0 forces port inputs zero
// - stop pin port floats in stop
// - two-bit field selects warm-up count
// - stop control bits 1:0 undefined
// - slow cpu cycle four fs periods
// - normal cpu cycle four fc periods
// - halt bit cleared on sleep0 release
// - level release: pin high or key
// - edge release: stop pin rising edge
`timescale 1ns/1ps
`include "lpm_defs.vh"

module lpm_mode_ctrl #(
   parameter PORT_W = 8,
   parameter CNT_W  = 18
) (
   input  wire              clk,
   input  wire              rst_n,
   input  wire [31:0]       haddr,
   input  wire [1:0]        htrans,
   input  wire              hwrite,
   input  wire [2:0]        hsize,
   input  wire [31:0]       hwdata,
   input  wire              hsel,
   input  wire              hready,
   output reg  [31:0]       hrdata,
   output wire              hreadyout,
   output wire              hresp,
   input  wire              fc_tick,
   input  wire              fs_tick,
   input  wire              tb_src_clk,
   input  wire              stop_pin,
   input  wire              key_wakeup,
   input  wire              reset_pin_release,
   input  wire [PORT_W-1:0] port_out,
   input  wire [PORT_W-1:0] port_in,
   output reg  [PORT_W-1:0] port_pin_out,
   output reg  [PORT_W-1:0] port_pin_oe,
   output reg  [PORT_W-1:0] port_in_core,
   output reg               stop_port_oe,
   output reg               cpu_run,
   output reg               periph_clk_en,
   output reg               osc_high_en,
   output reg               osc_low_en,
   output reg               cpu_cycle_tick,
   output reg               timebase_interrupt,
   output reg               timebase_irq_take
);

   // mode codes
   localparam M_NORMAL1 = 3'd0;
   localparam M_NORMAL2 = 3'd1;
   localparam M_SLOW2   = 3'd2;
   localparam M_SLOW1   = 3'd3;
   localparam M_SLEEP0  = 3'd4;
   localparam M_STOP    = 3'd5;
   localparam M_WARMUP  = 3'd6;

   // warm-up length from field and return mode
   function [CNT_W-1:0] wu_count;
      input [1:0] sel;
      input       slow;
      reg   [31:0] v;
      begin
         case ({slow, sel})
            3'b000:  v = `LPM_WU_N0;
            3'b001:  v = `LPM_WU_N1;
            3'b010:  v = `LPM_WU_N2;
            3'b011:  v = `LPM_WU_N3;
            3'b100:  v = `LPM_WU_S0;
            3'b101:  v = `LPM_WU_S1;
            3'b110:  v = `LPM_WU_S2;
            default: v = `LPM_WU_S3;
         endcase
         wu_count = v[CNT_W-1:0];
      end
   endfunction

   reg  [7:0]       stop_mode_control;
   reg  [7:0]       clock_source_control;
   reg  [2:0]       tb_ctrl;
   reg  [2:0]       mode;
   reg  [CNT_W-1:0] wu_cnt;
   reg              wu_slow;
   reg              sleep_tb_armed;
   reg              tb_src_q;
   reg              stop_pin_q;
   reg              level_armed;
   reg  [1:0]       mcyc_cnt;
   reg              a_wr;
   reg              a_rd;
   reg  [7:0]       a_addr;

   wire release_method        = stop_mode_control[`LPM_RELEASE_METHOD_BIT];
   wire post_stop_return_mode = stop_mode_control[`LPM_POST_STOP_RETURN_MODE_BIT];
   wire port_hold_in_stop     = stop_mode_control[`LPM_HOLD_BIT];
   wire [1:0] warmup_select   = stop_mode_control[`LPM_WUT_HI:`LPM_WUT_LO];
   wire peripheral_clock_halt = clock_source_control[`LPM_HALT_BIT];
   wire timebase_enable       = tb_ctrl[`LPM_TBEN_BIT];
   wire timebase_irq_enable   = tb_ctrl[`LPM_TBIE_BIT];
   wire interrupt_master_en   = tb_ctrl[`LPM_IME_BIT];
   wire tb_fall               = tb_src_q & ~tb_src_clk;
   wire pin_rise              = stop_pin & ~stop_pin_q;
   wire is_slow               = (mode == M_SLOW1) || (mode == M_SLOW2);
   wire src_tick              = wu_slow ? fs_tick : fc_tick;
   wire cyc_src               = is_slow ? fs_tick : fc_tick;
   wire bus_go                = hsel & hready & htrans[1];
   wire stop_req              = a_wr & (a_addr == `LPM_ADDR_STOP_CTRL) & hwdata[`LPM_STOP_BIT];
   wire halt_req              = a_wr & (a_addr == `LPM_ADDR_CLK_CTRL) & hwdata[`LPM_HALT_BIT];
   wire lvl_rel               = stop_pin | key_wakeup;
   wire do_release            = release_method ? (lvl_rel & level_armed) : pin_rise;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ==========================================
   // bus address phase capture
   always @(posedge clk) begin
      if (!rst_n) begin
         a_wr   <= 1'b0;
         a_rd   <= 1'b0;
         a_addr <= 8'h00;
      end else begin
         a_wr   <= bus_go & hwrite;
         a_rd   <= bus_go & ~hwrite;
         a_addr <= haddr[7:0];
      end
   end

   // read data mux, registered at address phase
   always @(posedge clk) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (bus_go & ~hwrite) begin
         case (haddr[7:0])
            `LPM_ADDR_STOP_CTRL: hrdata <= {24'h000000, stop_mode_control[7:2], 2'b00};
            `LPM_ADDR_CLK_CTRL:  hrdata <= {24'h000000, clock_source_control[7:4], 1'b0,
                                           clock_source_control[2], 2'b00};
            `LPM_ADDR_STATUS:    hrdata <= {24'h000000, timebase_interrupt, 4'h0, mode};
            `LPM_ADDR_TB_CTRL:   hrdata <= {29'h00000000, tb_ctrl};
            default:             hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================
   // edge detect sampling
   always @(posedge clk) begin
      if (!rst_n) begin
         tb_src_q   <= 1'b0;
         stop_pin_q <= 1'b0;
      end else begin
         tb_src_q   <= tb_src_clk;
         stop_pin_q <= stop_pin;
      end
   end

   // ==========================================
   // mode sequencer and control registers
   always @(posedge clk) begin
      if (!rst_n) begin
         stop_mode_control    <= `LPM_STOP_CTRL_RST;
         clock_source_control <= `LPM_CLK_CTRL_RST;
         tb_ctrl              <= 3'b000;
         mode                 <= M_NORMAL1;
         wu_cnt               <= {CNT_W{1'b0}};
         wu_slow              <= 1'b0;
         sleep_tb_armed       <= 1'b0;
         level_armed          <= 1'b0;
         timebase_interrupt   <= 1'b0;
      end else begin
         if (a_wr && a_addr == `LPM_ADDR_STOP_CTRL)
            stop_mode_control[7:2] <= {1'b0, hwdata[6:2]};
         if (a_wr && a_addr == `LPM_ADDR_CLK_CTRL)
            clock_source_control <= {hwdata[7:4], 1'b0, hwdata[2] & is_slow, 2'b00};
         if (a_wr && a_addr == `LPM_ADDR_TB_CTRL)
            tb_ctrl <= hwdata[2:0];
         // timebase latch clear by writing status bit 7
         if (a_wr && a_addr == `LPM_ADDR_STATUS && hwdata[7])
            timebase_interrupt <= 1'b0;
         if (a_wr && a_addr == `LPM_ADDR_CLK_CTRL && mode != M_STOP && mode != M_WARMUP)
            mode <= hwdata[`LPM_SYSCK_BIT] ? (hwdata[`LPM_XEN_BIT] ? M_SLOW2 : M_SLOW1)
                                           : (hwdata[`LPM_XTEN_BIT] ? M_NORMAL2 : M_NORMAL1);
         // level mode arms only once pin and key seen low
         if (!release_method || !lvl_rel)
            level_armed <= release_method;
         case (mode)
            M_SLEEP0: begin
               if (tb_fall) begin
                  mode <= M_SLOW1;
                  clock_source_control[`LPM_HALT_BIT] <= 1'b0;
                  if (sleep_tb_armed)
                     timebase_interrupt <= 1'b1;
               end
            end
            M_STOP: begin
               if (reset_pin_release) begin
                  wu_slow <= 1'b0;
                  wu_cnt  <= wu_count(warmup_select, 1'b0);
                  stop_mode_control[`LPM_POST_STOP_RETURN_MODE_BIT] <= 1'b0;
                  mode    <= M_WARMUP;
               end else if (do_release) begin
                  wu_cnt  <= wu_count(warmup_select, post_stop_return_mode);
                  wu_slow <= post_stop_return_mode;
                  mode    <= M_WARMUP;
               end
            end
            M_WARMUP: begin
               if (src_tick) begin
                  if (wu_cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                     mode <= wu_slow ? M_SLOW1 : M_NORMAL1;
                     stop_mode_control[`LPM_STOP_BIT] <= 1'b0;
                  end else begin
                     wu_cnt <= wu_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                  end
               end
            end
            default: begin
               if (stop_req) begin
                  stop_mode_control[`LPM_STOP_BIT] <= 1'b1;
                  mode <= M_STOP;
               end else if (halt_req && mode == M_SLOW1) begin
                  sleep_tb_armed <= timebase_enable;
                  mode           <= M_SLEEP0;
               end
            end
         endcase
      end
   end

   // ==========================================
   // machine cycle divider
   always @(posedge clk) begin
      if (!rst_n) begin
         mcyc_cnt       <= 2'd0;
         cpu_cycle_tick <= 1'b0;
      end else begin
         cpu_cycle_tick <= 1'b0;
         if (cpu_run && cyc_src) begin
            mcyc_cnt <= mcyc_cnt + 2'd1;
            if (mcyc_cnt == 2'd3)
               cpu_cycle_tick <= 1'b1;
         end
      end
   end

   // ==========================================
   // clock gates, pins and interrupt take
   always @(posedge clk) begin
      if (!rst_n) begin
         cpu_run           <= 1'b1;
         periph_clk_en     <= 1'b1;
         osc_high_en       <= 1'b1;
         osc_low_en        <= 1'b0;
         port_pin_out      <= {PORT_W{1'b0}};
         port_pin_oe       <= {PORT_W{1'b0}};
         port_in_core      <= {PORT_W{1'b0}};
         stop_port_oe      <= 1'b0;
         timebase_irq_take <= 1'b0;
      end else begin
         // cpu and peripherals stop in sleep0
         cpu_run       <= (mode != M_SLEEP0) && (mode != M_STOP) && (mode != M_WARMUP);
         periph_clk_en <= (mode != M_SLEEP0) && (mode != M_STOP) && (mode != M_WARMUP);
         osc_high_en   <= (mode == M_NORMAL1) || (mode == M_NORMAL2) || (mode == M_SLOW2)
                          || (mode == M_WARMUP && !wu_slow);
         osc_low_en    <= (mode != M_NORMAL1) && (mode != M_STOP);
         port_pin_out  <= port_out;
         port_pin_oe   <= (mode == M_STOP && !port_hold_in_stop) ? {PORT_W{1'b0}} : {PORT_W{1'b1}};
         port_in_core  <= (mode == M_STOP && !port_hold_in_stop) ? {PORT_W{1'b0}} : port_in;
         stop_port_oe  <= 1'b0;
         timebase_irq_take <= timebase_interrupt & interrupt_master_en & timebase_irq_enable
                              & timebase_enable & cpu_run;
      end
   end

endmodule // lpm_mode_ctrl

// ===== tb/lpm_far_side.sv
// far side model: oscillators and time base source
`timescale 1ns/1ps
module lpm_far_side (
   input  logic clk,
   input  logic osc_high_en,
   input  logic osc_low_en,
   output logic fc_tick,
   output logic fs_tick,
   output logic tb_src_clk
);
   logic [1:0] fs_div = 2'h0;
   logic [3:0] tb_div = 4'h0;
   initial fc_tick = 1'b0;
   initial fs_tick = 1'b0;
   initial tb_src_clk = 1'b1;
   // ==========================================
   // oscillators tick only while enabled
   always @(posedge clk) begin
      fc_tick <= osc_high_en & ~fc_tick;
      fs_div  <= osc_low_en ? fs_div + 2'h1 : 2'h0;
      fs_tick <= osc_low_en & (fs_div == 2'h3);
      if (osc_low_en & (fs_div == 2'h3)) begin
         tb_div <= tb_div + 4'h1;
         if (tb_div == 4'hF) tb_src_clk <= ~tb_src_clk;
      end
   end
endmodule // lpm_far_side

// ===== tb/lpm_props_properties.sv
// port assertions for the low power mode controller
`timescale 1ns/1ps
module lpm_props #(
   parameter PORT_W = 8,
   parameter CNT_W  = 18
) (
   input logic              clk,
   input logic              rst_n,
   input logic              fs_tick,
   input logic [PORT_W-1:0] port_pin_out,
   input logic [PORT_W-1:0] port_pin_oe,
   input logic              stop_port_oe,
   input logic              cpu_run,
   input logic              periph_clk_en,
   input logic              osc_high_en,
   input logic              osc_low_en,
   input logic              cpu_cycle_tick,
   input logic              timebase_interrupt,
   input logic              timebase_irq_take
);
   logic       stopped;
   logic       armed;
   logic [3:0] fs_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // helpers: stop state, fs ticks per machine cycle
   assign stopped = !osc_high_en && !osc_low_en;
   always @(posedge clk) begin
      if (!rst_n || !cpu_run || osc_high_en) begin
         fs_cnt <= 4'h0;
         armed  <= 1'b0;
      end else if (cpu_cycle_tick) begin
         fs_cnt <= 4'h0;
         armed  <= 1'b1;
      end else begin
         fs_cnt <= fs_cnt + {3'h0, fs_tick};
      end
   end
   // ==========================================
   // sleep and wake steps
   sequence s_asleep;
      !cpu_run && !periph_clk_en && osc_low_en && !osc_high_en;
   endsequence
   sequence s_wake;
      $rose(cpu_run);
   endsequence
   // ==========================================
   // properties
   a_stop_halts: assert property (stopped |-> !cpu_run && !periph_clk_en)
      else $error("core running in stop");
   a_stop_holds: assert property (stopped && $past(stopped) |-> $stable(port_pin_out) && $stable(port_pin_oe))
      else $error("port state moved in stop");
   a_stop_pin_hiz: assert property (stopped |-> !stop_port_oe)
      else $error("stop pin driven in stop");
   a_sleep_gate: assert property ($fell(periph_clk_en) && osc_low_en && !osc_high_en |-> !cpu_run)
      else $error("cpu left running in sleep");
   a_wake_slow: assert property (s_asleep ##1 s_wake |-> periph_clk_en && !osc_high_en)
      else $error("wake not into slow1");
   a_take_latch: assert property (timebase_irq_take |-> timebase_interrupt || $past(timebase_interrupt))
      else $error("irq taken without latch");
   a_tick_idle: assert property (!cpu_run [*2] |-> !cpu_cycle_tick)
      else $error("machine cycle while halted");
   a_slow_cycle: assert property (cpu_cycle_tick && armed |-> fs_cnt + {3'h0, fs_tick} == 4'h4)
      else $error("slow machine cycle not four fs");
endmodule // lpm_props
bind lpm_mode_ctrl lpm_props #(.PORT_W(PORT_W), .CNT_W(CNT_W)) lpm_props_i (
   .clk(clk), .rst_n(rst_n), .fs_tick(fs_tick), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
   .stop_port_oe(stop_port_oe), .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
   .osc_high_en(osc_high_en), .osc_low_en(osc_low_en), .cpu_cycle_tick(cpu_cycle_tick),
   .timebase_interrupt(timebase_interrupt), .timebase_irq_take(timebase_irq_take));

// ===== tb/tb_lpm_mode_ctrl.sv
// self-checking bench for the low power mode controller
`timescale 1ns/1ps
`include "lpm_defs.vh"
module tb_lpm_mode_ctrl;
   logic        clk, rst_n, hwrite, hsel, stop_pin, rp_rel, key;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, rdat;
   logic [7:0]  port_out, port_in;
   logic [7:0]  code [4] = '{8'h80, 8'hC0, 8'hE0, 8'h60};
   wire  [31:0] hrdata;
   wire  [7:0]  pin_out, pin_oe, in_core;
   wire         hreadyout, hresp, fc_tick, fs_tick, tb_src, stop_oe, cpu_run, pclk_en;
   wire         osc_h, osc_l, cyc_tick, tb_irq, tb_take;
   int          err_total, check_count, n, cnt;
   lpm_mode_ctrl lpm_mode_ctrl_i (
      .clk(clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .fc_tick(fc_tick), .fs_tick(fs_tick), .tb_src_clk(tb_src), .stop_pin(stop_pin),
      .key_wakeup(key), .reset_pin_release(rp_rel), .port_out(port_out), .port_in(port_in),
      .port_pin_out(pin_out), .port_pin_oe(pin_oe), .port_in_core(in_core), .stop_port_oe(stop_oe),
      .cpu_run(cpu_run), .periph_clk_en(pclk_en), .osc_high_en(osc_h), .osc_low_en(osc_l),
      .cpu_cycle_tick(cyc_tick), .timebase_interrupt(tb_irq), .timebase_irq_take(tb_take));
   lpm_far_side lpm_far_side_i (.clk(clk), .osc_high_en(osc_h), .osc_low_en(osc_l),
      .fc_tick(fc_tick), .fs_tick(fs_tick), .tb_src_clk(tb_src));
   // ==========================================
   // compare, bus and verdict tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rdat = hrdata;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic wmode(input logic [2:0] m);
      n = 0;
      do begin
         bus(1'b0, `LPM_ADDR_STATUS, 32'h0);
         n++;
      end while (rdat[2:0] !== m && n < 20000);
      chk({29'h0, rdat[2:0]}, {29'h0, m});
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #1800000;
      err_total++;
      conclude;
   end
   // ==========================================
   // test sequence
   initial begin
      {rst_n, hwrite, stop_pin, rp_rel, key, htrans, haddr, hwdata} = '0;
      {hsel, hsize, port_out, port_in} = {1'b1, 3'h2, 8'h3C, 8'hA5};
      {err_total, check_count} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(`LPM_ADDR_STOP_CTRL, 32'h00);
      rchk(`LPM_ADDR_CLK_CTRL, 32'h80);
      rchk(`LPM_ADDR_STATUS, 32'h00);
      rchk(32'h5C, 32'h00);
      bus(1'b1, `LPM_ADDR_STOP_CTRL, 32'h53);
      rchk(`LPM_ADDR_STOP_CTRL, 32'h50); // low bits zero
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `LPM_ADDR_CLK_CTRL, {24'h0, code[i]});
         wmode(i[2:0]); // run modes
      end
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, `LPM_ADDR_TB_CTRL, k ? 32'h0 : 32'h7);
         bus(1'b1, `LPM_ADDR_STATUS, 32'h80);
         @(posedge tb_src);
         bus(1'b1, `LPM_ADDR_CLK_CTRL, 32'h64); // halt bit
         repeat (3) @(posedge clk);
         chk({cpu_run, pclk_en}, 2'b00); // clocks withheld
         wmode(3'h3); // back to slow1
         rchk(`LPM_ADDR_CLK_CTRL, 32'h60); // halt cleared
         chk({tb_irq, tb_take}, k ? 2'b00 : 2'b11); // latch and take
      end
      bus(1'b1, `LPM_ADDR_STOP_CTRL, 32'hAC); // slow stop
      repeat (3) @(posedge clk);
      chk({osc_h, osc_l, stop_oe, pin_oe, in_core}, 19'h0); // floated
      rchk(`LPM_ADDR_STATUS, 32'h05);
      rchk(`LPM_ADDR_STOP_CTRL, 32'hAC);
      stop_pin <= 1'b1;
      {cnt, n} = '0;
      while (cpu_run !== 1'b1 && n < 4000) begin
         @(posedge clk);
         cnt += fs_tick;
         n++;
      end
      chk(cnt >= 64 && cnt <= 66, 1); // fs warm-up
      wmode(3'h3); // slow return
      bus(1'b1, `LPM_ADDR_CLK_CTRL, 32'h80);
      wmode(3'h0);
      stop_pin <= 1'b0;
      bus(1'b1, `LPM_ADDR_STOP_CTRL, 32'hDC); // level stop
      repeat (3) @(posedge clk);
      chk(pin_out, 8'h3C); // output kept
      rchk(`LPM_ADDR_STATUS, 32'h05);
      stop_pin <= 1'b1;
      wmode(3'h0); // normal return
      stop_pin <= 1'b0;
      bus(1'b1, `LPM_ADDR_CLK_CTRL, 32'h60);
      wmode(3'h3);
      bus(1'b1, `LPM_ADDR_STOP_CTRL, 32'hFC); // level stop for key
      rchk(`LPM_ADDR_STATUS, 32'h05);
      key <= 1'b1;
      wmode(3'h3); // key wakeup release
      key <= 1'b0;
      bus(1'b1, `LPM_ADDR_CLK_CTRL, 32'h80);
      wmode(3'h0);
      bus(1'b1, `LPM_ADDR_STOP_CTRL, 32'hAC);
      rchk(`LPM_ADDR_STATUS, 32'h05);
      rp_rel <= 1'b1;
      wmode(3'h0); // reset pin release
      rp_rel <= 1'b0;
      conclude;
   end
endmodule // tb_lpm_mode_ctrl
